// [core/aiding_packet_payload_codec.v]
/*
  Payload codec for the wheel-speed, air-data, velocity-log and gimbal
  aiding packets: checks received payloads, stores their fields and
  serialises stored air, velocity-log and gimbal payloads on read.
  Assumes a framer outside delivers id, bytes and an end strobe with
  header and checksum already checked, all synchronous to clk.
*/
// Summary of operation
// RULE_01: wheel packet id 67, 13 bytes, write only
// RULE_02: wheel fields delay, speed, reserved, flags
// RULE_03: sender sets reversing bit, zeroes the rest
// RULE_04: air packet id 68, 25 bytes, both ways
// RULE_05: air six floats then flag byte
// RULE_06: air flags altitude, airspeed, reference reset
// RULE_07: sender flags reference reset after change
// RULE_08: velocity log id 70, 60 bytes, both ways
// RULE_09: velocity log seconds, microseconds, flag word
// RULE_10: bottom then water velocities with deviations
// RULE_11: layer depth, depth, altitude, temperature last
// RULE_12: velocity log flags bottom, water, temp, depth, altitude
// RULE_13: gimbal id 72, 8 bytes, angle plus reserved
// RULE_14: accept gimbal angle strictly inside plus/minus two pi
// RULE_15: gimbal read angle wrapped into plus/minus pi
// RULE_16: wrong length payload dropped, nothing updated
// RULE_17: reserved ignored on receive, zero on transmit
`timescale 1ns/1ps
`include "codec_consts.vh"

module aiding_packet_payload_codec (
  input  wire         clk,         // 40 MHz clock
  input  wire         rst_b,       // async reset, active low
  input  wire         rx_start,    // pulse: new payload begins
  input  wire [7:0]   rx_id,       // packet id, valid with rx_start
  input  wire         rx_valid,    // pulse: rx_byte valid
  input  wire [7:0]   rx_byte,     // payload byte
  input  wire         rx_end,      // pulse: payload complete
  input  wire         tx_req,      // pulse: read request
  input  wire [7:0]   tx_id,       // id to read, valid with tx_req
  input  wire         tx_ready,    // framer takes tx_byte
  output reg          rx_ok,       // pulse: payload stored
  output reg          rx_drop,     // pulse: payload discarded
  output reg  [7:0]   rx_done_id,  // id of last payload ended by rx_end, also for ids with no rx_ok/rx_drop
  output reg          tx_valid,    // tx_byte valid
  output reg  [7:0]   tx_byte,     // payload byte out
  output reg          tx_last,     // last byte of payload
  output reg  [5:0]   tx_len,      // length of payload being sent
  output reg          tx_nak,      // pulse: read refused
  output reg  [103:0] wheel_img,   // wheel payload, byte 0 in [7:0]
  output reg  [199:0] air_img,     // air payload, byte 0 in [7:0]
  output reg  [479:0] dvl_img,     // velocity log payload, byte 0 in [7:0]
  output reg  [31:0]  gim_angle    // gimbal angle as written
);

  localparam RX_IDLE = 1'b0;
  localparam RX_BODY = 1'b1;
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  reg         rx_state_reg;
  reg  [7:0]  rx_id_reg;
  reg  [5:0]  rx_cnt_reg;
  reg  [479:0] rx_buf_reg;
  reg         tx_state_reg;
  reg  [5:0]  tx_cnt_reg;
  reg  [479:0] tx_sh_reg;

  // defined payload length, zero for ids this block does not own
  function [5:0] len_of;
    input [7:0] id;
    begin
      case (id)
        `ID_WHEEL:  len_of = `LEN_WHEEL;   // RULE_01
        `ID_AIR:    len_of = `LEN_AIR;     // RULE_04
        `ID_DVL:    len_of = `LEN_DVL;     // RULE_08
        `ID_GIMBAL: len_of = `LEN_GIMBAL;  // RULE_13
        default:    len_of = 6'h00;
      endcase
    end
  endfunction

  // wrap |a| in (pi, 2pi) by 2pi, done in Q3.29 fixed point; small
  // results lose low mantissa bits, fine for an angle report
  function [31:0] wrap_angle;
    input [31:0] a;
    reg   [31:0] fx;
    reg   [31:0] d;
    reg   [5:0]  sh;
    integer      p;
    integer      i;
    begin
      sh = (a[30:23] == `F_EXP_TWO) ? `FIX_SH_LO : `FIX_SH_HI;
      fx = {8'h00, 1'b1, a[22:0]} << sh;
      d = `FIX_TWO_PI - fx;
      p = 0;
      for (i = 0; i < 32; i = i + 1) begin
        if (d[i])
          p = i;
      end
      d = d << (31 - p);
      if (a[30:0] <= `F_PI_MAG)
        wrap_angle = a;
      else
        wrap_angle = {~a[31], p[7:0] + `FIX_EXP_ADJ, d[30:8]};  // RULE_15
    end
  endfunction

  wire [31:0] tx_angle   = wrap_angle(gim_angle);  // RULE_15
  wire [5:0]  rx_len_exp = len_of(rx_id_reg);
  wire [31:0] rx_angle   = rx_buf_reg[`OFS_G_ANGLE*8 +: 32];
  wire        angle_ok   = rx_angle[30:0] < `F_TWO_PI_MAG;  // RULE_14
  wire        len_ok     = (rx_len_exp != 6'h00) && (rx_cnt_reg == rx_len_exp);  // RULE_16
  wire        rx_accept  = len_ok && ((rx_id_reg != `ID_GIMBAL) || angle_ok);

  // receive: gather bytes, then commit whole payload or nothing
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_reg <= RX_IDLE;
      rx_id_reg    <= 8'h00;
      rx_cnt_reg   <= 6'h00;
      rx_buf_reg   <= 480'h0;
      rx_ok        <= 1'b0;
      rx_drop      <= 1'b0;
      rx_done_id   <= 8'h00;
      wheel_img    <= 104'h0;
      air_img      <= 200'h0;
      dvl_img      <= 480'h0;
      gim_angle    <= 32'h0000_0000;
    end else begin
      rx_ok   <= 1'b0;
      rx_drop <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state_reg <= RX_BODY;
            rx_id_reg    <= rx_id;
            rx_cnt_reg   <= 6'h00;
            rx_buf_reg   <= 480'h0;
          end
        end
        RX_BODY: begin
          if (rx_valid && !rx_end) begin
            if (rx_cnt_reg < `LEN_MAX)
              rx_buf_reg[rx_cnt_reg*8 +: 8] <= rx_byte;
            if (rx_cnt_reg != `CNT_SAT)
              rx_cnt_reg <= rx_cnt_reg + 6'h01;
          end
          if (rx_end) begin
            rx_state_reg <= RX_IDLE;
            rx_done_id   <= rx_id_reg;
            if (rx_len_exp != 6'h00) begin
              rx_ok   <= rx_accept;
              rx_drop <= !rx_accept;  // RULE_16
            end
            if (rx_accept) begin
              case (rx_id_reg)
                `ID_WHEEL: begin
                  // reserved float and flag bits 1-7 not kept
                  wheel_img <= {{(8-`W_FLAG_BITS){1'b0}},
                                rx_buf_reg[`OFS_W_FLAGS*8 +: `W_FLAG_BITS],
                                32'h0000_0000,
                                rx_buf_reg[`OFS_W_DELAY*8 +: 64]};  // RULE_02 RULE_17
                end
                `ID_AIR: begin
                  air_img <= {{(8-`A_FLAG_BITS){1'b0}},
                              rx_buf_reg[`OFS_A_FLAGS*8 +: `A_FLAG_BITS],
                              rx_buf_reg[`OFS_A_ALT_DLY*8 +: 192]};  // RULE_05 RULE_06
                end
                `ID_DVL: begin
                  dvl_img <= {rx_buf_reg[`OFS_D_VALS*8 +: 384],
                              {(32-`D_FLAG_BITS){1'b0}},
                              rx_buf_reg[`OFS_D_FLAGS*8 +: `D_FLAG_BITS],
                              rx_buf_reg[`OFS_D_SEC*8 +: 64]};  // RULE_09 RULE_10 RULE_11 RULE_12
                end
                `ID_GIMBAL: begin
                  gim_angle <= rx_angle;  // RULE_13
                end
                default: begin
                  gim_angle <= gim_angle;
                end
              endcase
            end
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // transmit: wheel packet is never emitted; others shift out lsb first
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg   <= 6'h00;
      tx_sh_reg    <= 480'h0;
      tx_valid     <= 1'b0;
      tx_byte      <= 8'h00;
      tx_last      <= 1'b0;
      tx_len       <= 6'h00;
      tx_nak       <= 1'b0;
    end else begin
      tx_nak <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_req) begin
            case (tx_id)
              `ID_AIR: begin
                tx_state_reg <= TX_SEND;
                tx_len       <= `LEN_AIR;
                tx_byte      <= air_img[7:0];
                tx_sh_reg    <= {280'h0, air_img} >> 8;  // RULE_04
              end
              `ID_DVL: begin
                tx_state_reg <= TX_SEND;
                tx_len       <= `LEN_DVL;
                tx_byte      <= dvl_img[7:0];
                tx_sh_reg    <= dvl_img >> 8;  // RULE_08
              end
              `ID_GIMBAL: begin
                // upper word stays zero: reserved field
                tx_state_reg <= TX_SEND;
                tx_len       <= `LEN_GIMBAL;
                tx_byte      <= tx_angle[7:0];  // RULE_15
                tx_sh_reg    <= {448'h0, tx_angle} >> 8;  // RULE_17
              end
              default: begin
                tx_nak <= 1'b1;  // RULE_01
              end
            endcase
            tx_valid   <= (tx_id == `ID_AIR) || (tx_id == `ID_DVL) || (tx_id == `ID_GIMBAL);
            tx_cnt_reg <= 6'h00;
            tx_last    <= 1'b0;
          end
        end
        TX_SEND: begin
          if (tx_ready) begin
            if (tx_cnt_reg == tx_len - 6'h01) begin
              tx_state_reg <= TX_IDLE;
              tx_valid     <= 1'b0;
              tx_last      <= 1'b0;
            end else begin
              tx_byte    <= tx_sh_reg[7:0];
              tx_sh_reg  <= tx_sh_reg >> 8;
              tx_cnt_reg <= tx_cnt_reg + 6'h01;
              tx_last    <= (tx_cnt_reg + 6'h02 == tx_len);
            end
          end
          if (tx_req)
            tx_nak <= 1'b1;
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

endmodule // aiding_packet_payload_codec

// [inc/codec_consts.vh]
/*
  Constants for the aiding packet payload codec: packet identifiers,
  payload lengths, field byte offsets, flag bits and float32 limits.
  Assumes payloads are little-endian byte streams.
*/
`ifndef CODEC_CONSTS_VH
`define CODEC_CONSTS_VH

`define ID_WHEEL       8'h43
`define ID_AIR         8'h44
`define ID_DVL         8'h46
`define ID_GIMBAL      8'h48
`define LEN_WHEEL      6'h0d
`define LEN_AIR        6'h19
`define LEN_DVL        6'h3c
`define LEN_GIMBAL     6'h08
`define LEN_MAX        6'h3c
`define CNT_SAT        6'h3f

`define OFS_W_DELAY    0
`define OFS_W_SPEED    4
`define OFS_W_RSVD     8
`define OFS_W_FLAGS    12
`define OFS_A_ALT_DLY  0
`define OFS_A_FLAGS    24
`define OFS_D_SEC      0
`define OFS_D_USEC     4
`define OFS_D_FLAGS    8
`define OFS_D_VALS     12
`define OFS_G_ANGLE    0

`define W_FLAG_BITS    1
`define A_FLAG_BITS    3
`define D_FLAG_BITS    5

`define F_TWO_PI_MAG   31'h40c9_0fdb
`define F_PI_MAG       31'h4049_0fdb
`define F_EXP_TWO      8'h80
`define FIX_SH_LO      6'h07
`define FIX_SH_HI      6'h08
`define FIX_TWO_PI     32'hc90f_daa2
`define FIX_EXP_ADJ    8'h62

`endif

// [verif/codec_properties.sv]
/* port checker for the aiding payload codec
   bound onto the codec top, sees its ports only */
`timescale 1ns/1ps
module codec_properties (
  input logic         clk,       // clock
  input logic         rst_b,     // reset
  input logic         rx_end,    // end strobe
  input logic         rx_ok,     // stored
  input logic         rx_drop,   // dropped
  input logic         tx_req,    // read req
  input logic [7:0]   tx_id,     // read id
  input logic         tx_valid,  // byte valid
  input logic         tx_nak,    // refused
  input logic [5:0]   tx_len,    // length
  input logic [103:0] wheel_img, // wheel
  input logic [199:0] air_img,   // air
  input logic [31:0]  gim_angle  // angle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rx_answer_a: assert property ((rx_ok || rx_drop) |-> $past(rx_end) && !(rx_ok && rx_drop))
    else $error("rx answer off");
  wheel_ro_a: assert property (tx_req && tx_id == 8'h43 && !tx_valid |=> tx_nak && !tx_valid)
    else $error("wheel read not refused");
  read_len_a: assert property (tx_valid |-> tx_len inside {6'h19, 6'h3c, 6'h08})
    else $error("bad read length");
  gim_read_a: assert property (tx_req && tx_id == 8'h48 && !tx_valid |=> tx_valid && tx_len == 6'h08)
    else $error("gimbal read missing");
  rsvd_zero_a: assert property (wheel_img[103:64] == {7'h0, wheel_img[96], 32'h0})
    else $error("reserved not zero");
  angle_range_a: assert property (gim_angle[30:0] < 31'h40c9_0fdb)
    else $error("angle out of range stored");
  drop_frozen_a: assert property (rx_drop |-> $stable(air_img) && $stable(wheel_img) && $stable(gim_angle))
    else $error("dropped payload stored");
  air_update_a: assert property (!$stable(air_img) |-> rx_ok)
    else $error("air image changed");
endmodule // codec_properties
bind aiding_packet_payload_codec codec_properties u_codec_properties (.*);

// [verif/host_sink.sv]
/* far-side framer model taking read bytes
   assumes the bench picks prompt or stalling mode */
`timescale 1ns/1ps
module host_sink (
  input  logic clk,      // clock
  input  logic rst_b,    // reset
  input  logic slow,     // stall mode
  output logic tx_ready  // byte taken
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? 1'($urandom) : 1'b1;
  end
endmodule // host_sink

// [verif/tb_top.sv]
/* self-checking bench for the aiding payload codec
   assumes codec, host_sink and checker compiled first */
`timescale 1ns/1ps
module tb_top;
  logic         clk = 0, rst_b = 0, slow = 0, tx_ready;
  logic         rx_start = 0, rx_valid = 0, rx_end = 0, tx_req = 0;
  logic [7:0]   rx_id = 0, rx_byte = 0, tx_id = 0, rx_done_id, tx_byte;
  logic         rx_ok, rx_drop, tx_valid, tx_last, tx_nak;
  logic [5:0]   tx_len;
  logic [103:0] wheel_img;
  logic [199:0] air_img;
  logic [479:0] dvl_img, e;
  logic [31:0]  gim_angle;
  logic [31:0]  ang [5] = '{32'h40c9_0fdb, 32'hc0c9_0fdb, 32'h7f80_0000, 32'hc0c9_0fda, 32'h3f80_0000};
  logic [1:0]   res [5] = '{2'b01, 2'b01, 2'b01, 2'b10, 2'b10};
  logic [7:0]   pl [64];
  logic [9:0]   rxq [$];
  logic [15:0]  txq [$];
  logic [15:0]  q;
  int           fails = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  aiding_packet_payload_codec u_aiding_packet_payload_codec (.*);
  host_sink u_host_sink (.*);
  task automatic check(input logic [479:0] seen, input logic [479:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rnd;
    for (int i = 0; i < 64; i++) pl[i] = 8'($urandom);
  endtask
  // e tracks the last accepted payload, so a drop leaves it alone
  task automatic send(input logic [7:0] id, input int n, input logic [1:0] r);
    rxq.push_back({r, id});
    if (r[1]) e = '0;
    @(posedge clk);
    rx_start <= 1'b1;
    rx_id <= id;
    for (int i = 0; i < n; i++) begin
      if (r[1]) e[8*i+:8] = pl[i];
      @(posedge clk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_byte <= pl[i];
    end
    @(posedge clk);
    rx_start <= 1'b0;
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] id, input int n, input logic dc);
    for (int i = 0; i < n; i++) txq.push_back({dc && i < 2, 6'(n), i == n - 1, e[8*i+:8]});
    if (n == 0) rxq.push_back(10'h3ff);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_id <= id;
    @(posedge clk);
    tx_req <= 1'b0;
    for (int k = 0; k < 400 && txq.size() > 0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (rst_b && (rx_ok || rx_drop))
      check({rx_ok, rx_drop, rx_done_id}, rxq.size() ? rxq.pop_front() : 'x);
    if (rst_b && tx_nak)
      check(10'h3ff, rxq.size() ? rxq.pop_front() : 'x);
    if (rst_b && tx_valid && tx_ready) begin
      q = txq.size() ? txq.pop_front() : 'x;
      // low bytes free: the wrap may drop low mantissa bits
      check({q[15], tx_len, tx_last, q[15] ? q[7:0] : tx_byte}, q);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h43a5));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rnd();
    pl[12][0] = 1'b1;
    send(8'h43, 13, 2'b10);
    e[103:64] = {7'h0, e[96], 32'h0};
    check(wheel_img, e);
    rd(8'h43, 0, 0);
    rd(8'h31, 0, 0);
    rnd();
    pl[24][2] = 1'b1;
    send(8'h44, 25, 2'b10);
    e[199:195] = '0;
    check(air_img, e);
    slow <= 1'b1;
    rd(8'h44, 25, 0);
    slow <= 1'b0;
    rnd();
    send(8'h44, 24, 2'b01);
    check(air_img, e);
    send(8'h46, 60, 2'b10);
    e[95:69] = '0;
    check(dvl_img, e);
    rd(8'h46, 60, 0);
    send(8'h46, 61, 2'b01);
    e = '0;
    for (int k = 0; k < 5; k++) begin
      {pl[3], pl[2], pl[1], pl[0]} = ang[k];
      send(8'h48, 8, res[k]);
      check(gim_angle, e[31:0]);
    end
    send(8'h48, 7, 2'b01);
    e = 32'h3f80_0000;
    rd(8'h48, 8, 0);
    {pl[3], pl[2], pl[1], pl[0]} = 32'h4090_0000;
    send(8'h48, 8, 2'b10);
    e = 32'hbfe4_0000;
    rd(8'h48, 8, 1);
    close_out();
  end
endmodule // tb_top
